// ### core/multidrop_scan_select_fsm.sv
`timescale 1ns/1ps
module multidrop_scan_select_fsm #(
    parameter int NUM_PORTS = 3,
    parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001  // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [scan_select_pkg::ADDR_W-1:0] slot_id,
    output logic tdo,
    output logic tdo_oe,
    output logic [NUM_PORTS-1:0] local_tms,
    output logic [NUM_PORTS-1:0] port_active,
    output logic selected,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [scan_select_pkg::IR_W-1:0] cmd_data,
    output logic cmd_lost
);
    import scan_select_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Next TAP state from tms
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        unique case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction : tap_next

    // TAP state in which a port may move from or to a given parked state
    function automatic tap_state_t gate_state(input port_state_t p);
        unique case (p)
            PARKED_DATA_PAUSE_STATE: gate_state = TAP_PAUSE_DR;
            PARKED_INSTR_PAUSE_STATE: gate_state = TAP_PAUSE_IR;
            default: gate_state = TAP_IDLE;
        endcase
    endfunction : gate_state

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser for every backplane pin
    logic [SYNC_W-1:0] meta_q, meta_d;   // First stage, read by second only
    logic [SYNC_W-1:0] sync_q, sync_d;   // Second stage
    logic tck_prev_q, tck_prev_d;        // Edge finder on the clean test clock

    // Synchroniser next values
    always_comb begin
        meta_d = {slot_id, trst_n, tdi, tms, tck};
        sync_d = meta_q;
        tck_prev_d = sync_q[0];
    end

    // Synchroniser registers
    always_ff @(posedge ref_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
        tck_prev_q <= tck_prev_d;
    end

    logic tms_s, tdi_s, tap_rst, rise, fall;  // Clean pin views
    logic [ADDR_W-1:0] slot_s;                // Static slot address
    assign tms_s = sync_q[1];
    assign tdi_s = sync_q[2];
    assign tap_rst = reset | ~sync_q[3];
    assign slot_s = sync_q[10:4];
    assign rise = sync_q[0] & ~tck_prev_q;
    assign fall = ~sync_q[0] & tck_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // TAP, instruction path and selection controller
    tap_state_t tap_q, tap_d;            // Backplane TAP state
    sel_state_t sel_q, sel_d;            // Selection controller state
    logic [IR_W-1:0] ir_q, ir_d;         // Updated instruction
    logic [IR_W-1:0] ir_sh_q, ir_sh_d;   // Instruction shift stage
    logic [DR_W-1:0] dr_q, dr_d;         // Shared data shift stage
    logic [2:0] grp_q, grp_d;            // Group membership register
    logic tdo_q, tdo_d;                  // Data output, falling edge
    logic oe_q, oe_d;                    // Data output enable
    logic push;                          // Level-two update into buffer
    logic l2_upd;                        // Level-two update pulse to ports
    dr_kind_t dr_kind;                   // Register in the data path

    // Register chosen by the current instruction
    always_comb begin
        if (ir_q == IDCODE_CMD) begin
            dr_kind = DR_IDCODE;
        end else if (ir_q == GROUP_REG_SELECT_CMD && sel_q == SEL_SINGLE) begin
            dr_kind = DR_GROUP;
        end else begin
            // Other register selects are outside this block; bypass stands in
            dr_kind = DR_BYPASS;
        end
    end

    // Controller next values
    always_comb begin
        tap_d = tap_q;
        sel_d = sel_q;
        ir_d = ir_q;
        ir_sh_d = ir_sh_q;
        dr_d = dr_q;
        grp_d = grp_q;
        tdo_d = tdo_q;
        oe_d = oe_q;
        push = 1'h0;
        l2_upd = 1'h0;
        if (tap_rst) begin
            // Test reset and hardware reset
            tap_d = TAP_RESET;
            sel_d = SEL_WAIT;
            ir_d = IR_RESET;
            oe_d = 1'h0;
            if (reset) begin
                grp_d = GROUP_RESET;
            end
        end else if (rise) begin
            tap_d = tap_next(tap_q, tms_s);
            unique case (tap_q)
                TAP_CAP_IR: begin
                    ir_sh_d = IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    ir_sh_d = {tdi_s, ir_sh_q[IR_W-1:1]};  // MSB entry
                end
                TAP_CAP_DR: begin
                    unique case (dr_kind)
                        DR_IDCODE: dr_d = IDCODE_VALUE;
                        DR_GROUP: dr_d = {29'h0, grp_q};
                        DR_BYPASS: dr_d = '0;
                    endcase
                end
                TAP_SHIFT_DR: begin
                    dr_d = {1'h0, dr_q[DR_W-1:1]};
                    unique case (dr_kind)
                        DR_IDCODE: dr_d[31] = tdi_s;
                        DR_GROUP: dr_d[2] = tdi_s;
                        DR_BYPASS: dr_d[0] = tdi_s;
                    endcase
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            // Output changes on falling edge; driven only singly selected
            tdo_d = (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
            oe_d = (tap_q == TAP_SHIFT_IR || tap_q == TAP_SHIFT_DR) && sel_q == SEL_SINGLE;
            if (tap_q == TAP_UPD_IR) begin
                if (sel_q == SEL_WAIT) begin
                    // Address match; ports stay parked, IR stays in chain
                    ir_d = IDCODE_CMD;
                    if (ir_sh_q[ADDR_W-1:0] == slot_s) begin
                        sel_d = SEL_SINGLE;
                    end else if (ir_sh_q[ADDR_W-1:0] == BCAST_ADDR) begin
                        sel_d = SEL_GROUP;
                    end else if (ir_sh_q[6:2] == MCAST_BASE[6:2] && grp_q[2]
                                 && grp_q[1:0] == ir_sh_q[1:0]) begin
                        sel_d = SEL_GROUP;
                    end else begin
                        sel_d = SEL_UNSEL;
                    end
                end else if (ir_sh_q == RETURN_TO_ADDRESS_WAIT_CMD) begin
                    sel_d = SEL_WAIT;  // Selected or not
                    ir_d = IDCODE_CMD;
                end else if (sel_q != SEL_UNSEL) begin
                    // Level-two decode only when selected
                    ir_d = ir_sh_q;
                    push = 1'h1;
                    l2_upd = 1'h1;
                end
            end
            if (tap_q == TAP_UPD_DR && dr_kind == DR_GROUP) begin
                grp_d = dr_q[2:0];  // Writable only singly selected
            end
        end
        if (!tap_rst && tap_q == TAP_RESET) begin
            sel_d = SEL_WAIT;
            ir_d = IR_RESET;
        end
    end

    // Controller registers
    always_ff @(posedge ref_clk) begin
        tap_q <= tap_d;
        sel_q <= sel_d;
        ir_q <= ir_d;
        ir_sh_q <= ir_sh_d;
        dr_q <= dr_d;
        grp_q <= grp_d;
        tdo_q <= tdo_d;
        oe_q <= oe_d;
    end

    assign tdo = tdo_q;
    assign tdo_oe = oe_q;
    assign selected = (sel_q == SEL_SINGLE) || (sel_q == SEL_GROUP);

    ////////////////////////////////////////////////////////////////////////////
    // Port configuration controllers, one per local port
    port_state_t port_q [NUM_PORTS];
    port_state_t port_d [NUM_PORTS];
    port_state_t tgt_q [NUM_PORTS];      // Pending destination
    port_state_t tgt_d [NUM_PORTS];
    logic [NUM_PORTS-1:0] pend_q, pend_d;    // A park or unpark is waiting
    logic [NUM_PORTS-1:0] ltms_q, ltms_d;    // Local mode-select pins

    // Port next values
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_d[i] = port_q[i];
            tgt_d[i] = tgt_q[i];
            pend_d[i] = pend_q[i];
            if (l2_upd && ir_sh_q[i]) begin
                if (ir_sh_q[7:5] == UNPARK_OP) begin
                    tgt_d[i] = UNPARKED_STATE;
                    pend_d[i] = 1'h1;
                end else if (ir_sh_q[7:5] == PARK_OP) begin
                    tgt_d[i] = port_state_t'({1'h0, ir_sh_q[4:3]});
                    pend_d[i] = 1'h1;
                end
            end else if (!selected) begin
                pend_d[i] = 1'h0;  // Unselected: commands dropped
            end else if (pend_q[i]) begin
                if (port_q[i] == UNPARKED_STATE && tgt_q[i] != UNPARKED_STATE) begin
                    // Park waits for the matching TAP state
                    if (tap_q == gate_state(tgt_q[i])) begin
                        port_d[i] = tgt_q[i];
                        pend_d[i] = 1'h0;
                    end
                end else if (port_q[i] != UNPARKED_STATE && tgt_q[i] == UNPARKED_STATE) begin
                    // Unpark from idle or reset only at Run-Test/Idle
                    if (tap_q == gate_state(port_q[i])) begin
                        port_d[i] = UNPARKED_STATE;
                        pend_d[i] = 1'h0;
                    end
                end else begin
                    pend_d[i] = 1'h0;  // Parked to parked is meaningless
                end
            end
            if (port_q[i] == UNPARKED_STATE && tap_q == TAP_RESET) begin
                port_d[i] = PARKED_RESET_STATE;  // Local chain followed into reset
            end
            if (reset) begin
                port_d[i] = PARKED_RESET_STATE;
                tgt_d[i] = PARKED_RESET_STATE;
                pend_d[i] = 1'h0;
            end
            // Parked level: high holds reset, low holds idle or pause
            unique case (port_d[i])
                UNPARKED_STATE: ltms_d[i] = tms_s;
                PARKED_RESET_STATE: ltms_d[i] = 1'h1;
                default: ltms_d[i] = 1'h0;
            endcase
        end
    end

    // Port registers
    always_ff @(posedge ref_clk) begin
        port_q <= port_d;
        tgt_q <= tgt_d;
        pend_q <= pend_d;
        ltms_q <= ltms_d;
    end

    assign local_tms = ltms_q;
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_active[i] = (port_q[i] == UNPARKED_STATE);  // In chain
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer for updated level-two instructions. The TAP cannot be
    // stalled, so a word arriving into a full buffer is flagged on cmd_lost.
    logic [IR_W-1:0] mem_q [2];
    logic [IR_W-1:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;        // Entry pointers
    logic [1:0] cnt_q, cnt_d;            // Fill count
    logic lost_q, lost_d;                // Dropped-word pulse
    logic in_ready;                      // Room for a word

    assign in_ready = (cnt_q != 2'h2);

    // Buffer next values
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        lost_d = push & ~in_ready;
        if (push && in_ready) begin
            mem_d[wr_q] = ir_sh_q;
            wr_d = ~wr_q;
        end
        if (cmd_valid && cmd_ready) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'h0, push & in_ready} - {1'h0, cmd_valid & cmd_ready};
        if (reset) begin
            wr_d = 1'h0;
            rd_d = 1'h0;
            cnt_d = 2'h0;
            lost_d = 1'h0;
        end
    end

    // Buffer registers
    always_ff @(posedge ref_clk) begin
        mem_q <= mem_d;
        wr_q <= wr_d;
        rd_q <= rd_d;
        cnt_q <= cnt_d;
        lost_q <= lost_d;
    end

    assign cmd_valid = (cnt_q != 2'h0);
    assign cmd_data = mem_q[rd_q];
    assign cmd_lost = lost_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_reset_state;
        @(posedge ref_clk) reset |=> tap_q == TAP_RESET && sel_q == SEL_WAIT
            && port_q[0] == PARKED_RESET_STATE && port_q[2] == PARKED_RESET_STATE;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");

    property p_wait_quiet;
        @(posedge ref_clk) disable iff (reset) sel_q == SEL_WAIT |=> !tdo_oe;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("driven in wait");

    property p_group_quiet;
        @(posedge ref_clk) disable iff (reset)
            sel_q == SEL_GROUP && $past(sel_q) == SEL_GROUP |-> !tdo_oe;
    endproperty
    a_group_quiet: assert property (p_group_quiet) else $error("group drives tdo");

    property p_slot_match;
        @(posedge ref_clk) disable iff (tap_rst)
            fall && tap_q == TAP_UPD_IR && sel_q == SEL_WAIT
            && ir_sh_q[6:0] == slot_s |=> sel_q == SEL_SINGLE;
    endproperty
    a_slot_match: assert property (p_slot_match) else $error("slot not selected");

    property p_bcast;
        @(posedge ref_clk) disable iff (tap_rst)
            fall && tap_q == TAP_UPD_IR && sel_q == SEL_WAIT && ir_sh_q[6:0] == 7'h3B
            && slot_s != 7'h3B |=> sel_q == SEL_GROUP;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast missed");

    property p_mismatch;
        @(posedge ref_clk) disable iff (tap_rst)
            fall && tap_q == TAP_UPD_IR && sel_q == SEL_WAIT && ir_sh_q[6:0] != slot_s
            && ir_sh_q[6:2] != 5'h0F && ir_sh_q[6:0] != 7'h3B |=> sel_q == SEL_UNSEL;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch selected");

    property p_tlr_wait;
        @(posedge ref_clk) disable iff (reset) tap_q == TAP_RESET |=> sel_q == SEL_WAIT;
    endproperty
    a_tlr_wait: assert property (p_tlr_wait) else $error("not waiting in reset");

    property p_group_locked;
        @(posedge ref_clk) disable iff (reset) sel_q != SEL_SINGLE |=> $stable(grp_q);
    endproperty
    a_group_locked: assert property (p_group_locked) else $error("group written");

    property p_unpark_idle;
        @(posedge ref_clk) disable iff (reset)
            port_q[0] == PARKED_IDLE_STATE ##1 port_q[0] == UNPARKED_STATE
            |-> $past(tap_q) == TAP_IDLE && $past(selected);
    endproperty
    a_unpark_idle: assert property (p_unpark_idle) else $error("early unpark");

    property p_idle_low;
        @(posedge ref_clk) disable iff (reset)
            port_q[1] == PARKED_IDLE_STATE ##1 port_q[1] == PARKED_IDLE_STATE
            |-> !local_tms[1];
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle park not low");

    property p_reset_high;
        @(posedge ref_clk) disable iff (reset)
            port_q[2] == PARKED_RESET_STATE ##1 port_q[2] == PARKED_RESET_STATE
            |-> local_tms[2];
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("reset park not high");

    property p_unsel_ignore;
        @(posedge ref_clk) disable iff (reset)
            sel_q == SEL_UNSEL && tap_q != TAP_RESET |=> $stable(port_q[0]);
    endproperty
    a_unsel_ignore: assert property (p_unsel_ignore) else $error("unselected moved");
endmodule : multidrop_scan_select_fsm

// ### core/scan_select_pkg.sv
package scan_select_pkg;
    localparam int IR_W = 8;                      // Instruction register width
    localparam int ADDR_W = 7;                    // Slot address width
    localparam int DR_W = 32;                     // Longest data register
    localparam int SYNC_W = 11;                   // Pins passed through synchroniser
    localparam logic [6:0] BCAST_ADDR = 7'h3B;    // Broadcast address
    localparam logic [6:0] MCAST_BASE = 7'h3C;    // Multicast group zero
    localparam logic [7:0] IR_CAPTURE = 8'h01;    // Capture-IR pattern
    // Level-two instruction codes
    localparam logic [7:0] BYPASS_CMD = 8'hFF;
    localparam logic [7:0] BOUNDARY_EXTERNAL_TEST_CMD = 8'h00;
    localparam logic [7:0] SAMPLE_PRELOAD_CMD = 8'h81;
    localparam logic [7:0] IDCODE_CMD = 8'h82;
    localparam logic [7:0] PORT_CONFIG_SELECT_CMD = 8'h83;
    localparam logic [7:0] GROUP_REG_SELECT_CMD = 8'h84;
    localparam logic [7:0] SIGNATURE_SELECT_CMD = 8'h85;
    localparam logic [7:0] CYCLE_COUNTER_SELECT_CMD = 8'h86;
    localparam logic [7:0] SIGNATURE_ENABLE_CMD = 8'h87;
    localparam logic [7:0] SIGNATURE_DISABLE_CMD = 8'h88;
    localparam logic [7:0] CYCLE_COUNTER_RUN_CMD = 8'h89;
    localparam logic [7:0] CYCLE_COUNTER_HALT_CMD = 8'h8A;
    localparam logic [7:0] RETURN_TO_ADDRESS_WAIT_CMD = 8'h8B;
    // Park and unpark: opcode in [7:5], park kind in [4:3], port mask in [2:0]
    localparam logic [2:0] PARK_OP = 3'h6;
    localparam logic [2:0] UNPARK_OP = 3'h5;
    localparam logic [1:0] PARK_KIND_RESET = 2'h0;
    localparam logic [1:0] PARK_IN_IDLE_CMD_KIND = 2'h1;
    localparam logic [1:0] PARK_KIND_DPAUSE = 2'h2;
    localparam logic [1:0] PARK_KIND_IPAUSE = 2'h3;
    // Values after reset
    localparam logic [7:0] IR_RESET = IDCODE_CMD;
    localparam logic [2:0] GROUP_RESET = 3'h0;    // {member, group}, no membership
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_t;
    typedef enum logic [1:0] {
        SEL_WAIT, SEL_UNSEL, SEL_SINGLE, SEL_GROUP
    } sel_state_t;
    typedef enum logic [2:0] {
        PARKED_RESET_STATE, PARKED_IDLE_STATE, PARKED_DATA_PAUSE_STATE,
        PARKED_INSTR_PAUSE_STATE, UNPARKED_STATE
    } port_state_t;
    typedef enum logic [1:0] {
        DR_BYPASS, DR_IDCODE, DR_GROUP
    } dr_kind_t;
endpackage : scan_select_pkg

// ### tb/scan_master_model.sv
`timescale 1ns/1ps
module scan_master_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic [7:0] tdo_bits = 8'h00; // Data output seen at the last eight rises
    logic [7:0] ir_out = 8'h00; // Bits shifted out by the last instruction scan
    // One 160 ns period; even halves keep pin changes just after a ref_clk edge
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        // Undriven output reads as its inverse, so a missing drive shows up
        tdo_bits = {(tdo_oe === 1'b1) ? tdo : ~tdo, tdo_bits[7:1]};
        #80 tck = 1'b0;
    endtask : step
    // Five ones reach Test-Logic-Reset, then park the TAP in idle
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : tap_reset
    // Instruction scan from idle, always ending back in idle
    task automatic load_ir(input logic [7:0] v);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) step(i == 7, v[i]); // LSB first
        ir_out = tdo_bits;
        step(1'b0, 1'b0); // Through Pause-IR on the way to Update-IR
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : load_ir
    // Three-bit data scan from idle, through Pause-DR, ending in idle
    task automatic load_dr(input logic [2:0] v);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) step(i == 2, v[i]);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : load_dr
    // Clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
endmodule : scan_master_model

// ### tb/multidrop_scan_select_fsm_test.sv
`timescale 1ns/1ps
module multidrop_scan_select_fsm_test;
    import scan_select_pkg::*;
    localparam logic [6:0] SLOT = 7'h12; // Clear of reserved range
    logic [6:0] slot_id = SLOT; // Strapped slot, moved once mid-run
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic trst_n = 1'b1;
    logic cmd_ready = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, selected, cmd_valid, cmd_lost;
    logic [2:0] local_tms, port_active;
    logic [7:0] cmd_data;
    logic oe_seen = 1'b0; // Sticky: data output was enabled
    logic lost_seen = 1'b0; // Sticky: a word was dropped
    int bad_count = 0;
    int comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////
    multidrop_scan_select_fsm u_dut (.ref_clk(ref_clk), .reset(reset), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .slot_id(slot_id), .tdo(tdo),
        .tdo_oe(tdo_oe), .local_tms(local_tms), .port_active(port_active),
        .selected(selected), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .cmd_lost(cmd_lost));
    scan_master_model u_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    // Pulses are short, so latch them for the scenarios
    always @(posedge ref_clk) begin
        if (tdo_oe === 1'b1) oe_seen <= 1'b1;
        if (cmd_lost === 1'b1) lost_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize();
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // Pop one buffered instruction, bounded wait
    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk) #1;
        while (cmd_valid !== 1'b1 && n < 50) begin
            @(posedge ref_clk) #1;
            n++;
        end
        check("cmd_valid", 8'h01, {7'h0, cmd_valid});
        if (cmd_valid !== 1'b1) summarize();
        check("cmd_data", exp, cmd_data);
        cmd_ready = 1'b1;
        @(posedge ref_clk) #1;
        cmd_ready = 1'b0;
    endtask : pop
    ////////////////////////////////////////////////////////////////////
    // Foreign address: unselected, output never enabled, ports deaf
    task automatic t_unselected();
        oe_seen = 1'b0;
        u_master.load_ir({1'b0, SLOT ^ 7'h01});
        u_master.load_ir(8'hA7);
        check("tdo", 8'hFE, u_master.ir_out);
        check("selected", 8'h00, {7'h0, selected});
        check("port_active", 8'h00, {5'h0, port_active});
        check("tdo_oe", 8'h00, {7'h0, oe_seen});
    endtask : t_unselected
    // Direct select, then park and unpark ports independently
    task automatic t_single();
        u_master.tap_reset();
        u_master.load_ir({1'b0, SLOT});
        check("selected", 8'h01, {7'h0, selected});
        check("port_active", 8'h00, {5'h0, port_active});
        u_master.load_ir(8'hA7);
        check("tdo", IR_CAPTURE, u_master.ir_out);
        check("port_active", 8'h07, {5'h0, port_active});
        u_master.load_ir(8'hC9);
        check("port_active", 8'h06, {5'h0, port_active});
        u_master.load_ir(8'hC2);
        check("port_active", 8'h04, {5'h0, port_active});
        check("local_tms", 8'h02, {5'h0, local_tms[1:0]});
        u_master.load_ir(8'hA1);
        check("port_active", 8'h05, {5'h0, port_active});
        check("tdo_oe", 8'h01, {7'h0, oe_seen});
    endtask : t_single
    // Pause parking: each port waits for its own pause state, both ways
    task automatic t_pause();
        u_master.load_ir(8'hD4);
        u_master.load_dr(3'h0);
        check("port_active", 8'h01, {5'h0, port_active});
        check("local_tms", 8'h02, {5'h0, local_tms});
        u_master.load_ir(8'hD9);
        u_master.load_ir(8'hA5);
        check("port_active", 8'h00, {5'h0, port_active});
        u_master.load_dr(3'h0);
        check("port_active", 8'h04, {5'h0, port_active});
        u_master.load_ir(BYPASS_CMD);
        check("port_active", 8'h05, {5'h0, port_active});
    endtask : t_pause
    // Stalled sink: third word dropped, first two kept in order
    task automatic t_buffer();
        cmd_ready = 1'b0;
        lost_seen = 1'b0;
        u_master.load_ir(IDCODE_CMD);
        u_master.load_ir(BYPASS_CMD);
        u_master.load_ir(SAMPLE_PRELOAD_CMD);
        check("cmd_lost", 8'h01, {7'h0, lost_seen});
        pop(IDCODE_CMD);
        pop(BYPASS_CMD);
        check("cmd_valid", 8'h00, {7'h0, cmd_valid});
        @(posedge ref_clk) #1;
        cmd_ready = 1'b1;
    endtask : t_buffer
    // Return command, broadcast, test reset, unjoined group
    task automatic t_modes();
        u_master.load_ir(RETURN_TO_ADDRESS_WAIT_CMD);
        check("selected", 8'h00, {7'h0, selected});
        u_master.load_ir(8'h3B);
        check("selected", 8'h01, {7'h0, selected});
        oe_seen = 1'b0;
        u_master.load_ir(BYPASS_CMD);
        check("tdo", 8'hFE, u_master.ir_out);
        check("tdo_oe", 8'h00, {7'h0, oe_seen});
        trst_n = 1'b0;
        repeat (6) @(posedge ref_clk) #1;
        trst_n = 1'b1;
        check("selected", 8'h00, {7'h0, selected});
        u_master.tap_reset();
        u_master.load_ir(8'h3C);
        check("selected", 8'h00, {7'h0, selected});
    endtask : t_modes
    // New slot; group written when singly selected only, then multicast
    task automatic t_group();
        slot_id = 7'h25;
        u_master.tap_reset();
        u_master.load_ir({1'b0, slot_id});
        check("selected", 8'h01, {7'h0, selected});
        u_master.load_ir(GROUP_REG_SELECT_CMD);
        u_master.load_dr(3'h5); // Member of group one
        u_master.load_ir(RETURN_TO_ADDRESS_WAIT_CMD);
        u_master.load_ir(8'h3D);
        check("selected", 8'h01, {7'h0, selected});
        u_master.load_ir(GROUP_REG_SELECT_CMD);
        u_master.load_dr(3'h6); // Group-selected: write must be ignored
        u_master.load_ir(RETURN_TO_ADDRESS_WAIT_CMD);
        u_master.load_ir(8'h3E);
        check("selected", 8'h00, {7'h0, selected});
    endtask : t_group
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk) #1;
        reset = 1'b0;
        repeat (3) @(posedge ref_clk) #1;
        check("port_active", 8'h00, {5'h0, port_active});
        check("local_tms", 8'h07, {5'h0, local_tms});
        u_master.tap_reset();
        t_unselected();
        t_single();
        t_pause();
        t_buffer();
        t_modes();
        t_group();
        summarize();
    end
    // Hang guard
    initial begin
        #300000;
        bad_count++;
        summarize();
    end
endmodule : multidrop_scan_select_fsm_test
